// *** hdl/ost_cfg.svh ***
`ifndef OST_CFG_SVH
`define OST_CFG_SVH
`define OST_CNT_W        32
`define OST_CMP_RST      32'h0000_0000
`define OST_CNT_ZERO     32'h0000_0000
`define OST_CNT_ONES     32'hffff_ffff
`define OST_MODE_RST     1'b0
`define OST_SIRQ_RST     1'b0
`endif

// *** hdl/ost_pkg.sv ***
package ost_pkg;
  typedef enum logic [0:0] {
    OST_INTERVAL = 1'b0,
    OST_FREERUN  = 1'b1
  } ost_mode_t;
  typedef struct packed {
    logic start;
    logic stop;
  } ost_trig_t;
  typedef struct packed {
    ost_mode_t mode_select;
    logic      start_irq_select;
  } ost_ctl_t;
endpackage

// *** hdl/ost_timer.sv ***
// What this block does
// - one 32-bit counter, readable, stepping on the count clock.
// - counts only on the count clock, no prescaler.
// - irq on underflow in interval mode, on compare match in free-run mode.
// - start-irq select adds an irq at every start and restart.
// - start trigger sets the enabled flag; trigger self-clears.
// - stop trigger clears the enabled flag; trigger self-clears.
// - a stopped counter holds its value.
// - mode select 0 is interval mode, 1 is free-run compare mode.
// - interval mode counts down from compare, irq when zero reached.
// - at zero, interval mode reloads from compare and keeps counting.
// - interval irq period is clock period times compare plus one.
// - compare writes in interval mode take effect at next reload.
// - interval restart after stop loads from current compare.
// - interval start while running reloads at once, start irq if selected.
// - interval compare zero keeps irq high while enabled, except the first clock without start irq; low when stopped.
// - free-run counts up from zero, wraps, irq when count equals compare.
// - free-run restart after stop begins from zero.
// - free-run ignores start while enabled.
// - free-run first match compare+1 clocks after start, then every 2^32.
// - free-run compare zero with start irq gives two clocks of irq.
// - mode control writes accepted only while counter disabled.
// - after mode change counter reads all ones (interval) or zero (free-run).
// - reset returns everything to initial values.
`timescale 1ns/1ps
`default_nettype none
`include "ost_cfg.svh"
module ost_timer #(
  parameter int CNT_W = `OST_CNT_W
) (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rstn,
  // compare value
  input  wire logic              i_compare_we,
  input  wire logic [CNT_W-1:0]  i_compare_value,
  // triggers
  input  wire ost_pkg::ost_trig_t i_trig,
  // mode control
  input  wire logic              i_mode_control_we,
  input  wire ost_pkg::ost_ctl_t i_mode_control,
  // status
  output logic [CNT_W-1:0]       o_compare_value,
  output logic [CNT_W-1:0]       o_count_value,
  output ost_pkg::ost_ctl_t      o_mode_control,
  output logic                   o_counter_enabled_flag,
  output logic                   o_start_trigger,
  output logic                   o_stop_trigger,
  output logic                   o_timer_irq
);

  // refuse widths that the fixed-width count and compare logic cannot serve
  if (CNT_W != 32) begin : g_bad_width
    $error("ost_timer: counter width must be 32");
  end

  // ==========================================================
  // state
  logic [CNT_W-1:0]  cmp_q;
  logic [CNT_W-1:0]  cnt_q;
  ost_pkg::ost_ctl_t ctl_q;
  logic              en_q;
  logic              irq_q;
  logic              go_start;
  logic              free_mode;
  logic              zero_hit;
  logic              match_hit;
  logic              run;

  assign free_mode = (ctl_q.mode_select == ost_pkg::OST_FREERUN);
  // start accepted unless free-run and already enabled
  assign go_start  = i_trig.start && !(free_mode && en_q);
  assign run       = en_q && !i_trig.stop;
  assign zero_hit  = !free_mode && en_q && (cnt_q == `OST_CNT_ZERO);
  assign match_hit = free_mode && en_q && (cnt_q == cmp_q);

  // ==========================================================
  // compare value
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cmp_q <= `OST_CMP_RST;
    end else if (i_compare_we) begin
      cmp_q <= i_compare_value;
    end
  end

  // ==========================================================
  // mode control
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctl_q.mode_select      <= ost_pkg::ost_mode_t'(`OST_MODE_RST);
      ctl_q.start_irq_select <= `OST_SIRQ_RST;
    end else if (i_mode_control_we && !en_q) begin
      ctl_q <= i_mode_control;
    end
  end

  // ==========================================================
  // enabled flag
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      en_q <= 1'b0;
    end else if (i_trig.stop) begin
      en_q <= 1'b0;
    end else if (i_trig.start) begin
      en_q <= 1'b1;
    end
  end

  // ==========================================================
  // counter
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_q <= `OST_CNT_ONES;
    end else if (i_mode_control_we && !en_q
                 && (i_mode_control.mode_select != ctl_q.mode_select)) begin
      cnt_q <= (i_mode_control.mode_select == ost_pkg::OST_FREERUN)
               ? `OST_CNT_ZERO : `OST_CNT_ONES;
    end else if (go_start && !i_trig.stop) begin
      cnt_q <= free_mode ? `OST_CNT_ZERO : cmp_q;
    end else if (run) begin
      if (free_mode) begin
        cnt_q <= cnt_q + 32'h0000_0001;
      end else if (zero_hit) begin
        cnt_q <= cmp_q;
      end else begin
        cnt_q <= cnt_q - 32'h0000_0001;
      end
    end
  end

  // ==========================================================
  // interrupt
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_q <= 1'b0;
    end else if (i_trig.stop) begin
      irq_q <= 1'b0;
    end else begin
      // one-cycle pulses; zero compare gives back-to-back events
      irq_q <= (go_start && ctl_q.start_irq_select)
               || zero_hit || match_hit;
    end
  end

  // ==========================================================
  // outputs
  assign o_compare_value        = cmp_q;
  assign o_count_value          = cnt_q;
  assign o_mode_control         = ctl_q;
  assign o_counter_enabled_flag = en_q;
  assign o_start_trigger        = 1'b0;
  assign o_stop_trigger         = 1'b0;
  assign o_timer_irq            = irq_q;

endmodule // ost_timer
`default_nettype wire

// *** verification/ost_timer_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module ost_timer_checker (
  input wire logic               i_clk,
  input wire logic               i_rstn,
  input wire logic               i_compare_we,
  input wire ost_pkg::ost_trig_t i_trig,
  input wire logic               i_mode_control_we,
  input wire logic [31:0]        o_compare_value,
  input wire logic [31:0]        o_count_value,
  input wire ost_pkg::ost_ctl_t  o_mode_control,
  input wire logic               o_counter_enabled_flag,
  input wire logic               o_timer_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  wire logic en = o_counter_enabled_flag;
  wire logic fr = o_mode_control.mode_select;
  wire logic sp = i_trig.stop;
  wire logic st = i_trig.start & ~sp;
  start_sets_a: assert property (st |=> en) else $error("start");
  stop_clears_a: assert property (sp |=> !en && !o_timer_irq) else $error("stop");
  count_down_a: assert property (en && !fr && !st && !sp && o_count_value != 0
    |=> o_count_value == $past(o_count_value) - 1) else $error("down");
  reload_a: assert property (en && !fr && !st && !sp && !i_compare_we && o_count_value == 0
    |=> o_timer_irq && o_count_value == $past(o_compare_value)) else $error("reload");
  count_up_a: assert property (en && fr && !sp
    |=> o_count_value == $past(o_count_value) + 1) else $error("up");
  match_a: assert property (en && fr && !sp && o_count_value == o_compare_value
    |=> o_timer_irq) else $error("match");
  start_load_a: assert property (st && !fr && !i_compare_we && !i_mode_control_we
    |=> o_count_value == $past(o_compare_value) && (!o_mode_control.start_irq_select || o_timer_irq))
    else $error("load");
  mode_lock_a: assert property (en && i_mode_control_we |=> $stable(o_mode_control))
    else $error("mode");
endmodule // ost_timer_checker
bind ost_timer ost_timer_checker i_chk (.i_clk(i_clk), .i_rstn(i_rstn),
  .i_compare_we(i_compare_we), .i_trig(i_trig), .i_mode_control_we(i_mode_control_we),
  .o_compare_value(o_compare_value), .o_count_value(o_count_value),
  .o_mode_control(o_mode_control), .o_counter_enabled_flag(o_counter_enabled_flag),
  .o_timer_irq(o_timer_irq));
`default_nettype wire

// *** verification/ost_timer_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module ost_timer_bench;
  logic clk = 0, rstn = 0, cwe = 0, mwe = 0, en, irq, sst, tst;
  logic [31:0] cv = 0, ocv, cnt, g;
  ost_pkg::ost_trig_t trig = '0;
  ost_pkg::ost_ctl_t  ctl = '0, m;
  int num_errors = 0, tests_run = 0, n;
  ost_timer i_dut (.i_clk(clk), .i_rstn(rstn), .i_compare_we(cwe), .i_compare_value(cv),
    .i_trig(trig), .i_mode_control_we(mwe), .i_mode_control(ctl), .o_compare_value(ocv),
    .o_count_value(cnt), .o_mode_control(m), .o_counter_enabled_flag(en),
    .o_start_trigger(sst), .o_stop_trigger(tst), .o_timer_irq(irq));
  initial forever #20 clk = ~clk;
  task automatic chk(input logic [31:0] a, b);
    tests_run++;
    if (a !== b) begin
      num_errors++;
      $display("ERROR %0t: got %h exp %h", $time, a, b);
    end
  endtask
  task automatic drv(input logic [1:0] t, input logic c, w, input logic [31:0] v,
                     input logic [1:0] k);
    @(negedge clk);
    trig = t; cwe = c; mwe = w; cv = v; ctl = k;
    @(negedge clk);
    trig = '0; cwe = 0; mwe = 0;
  endtask
  task automatic wirq;
    n = 0;
    do begin @(negedge clk); n++; end while (irq !== 1'b1 && n < 50);
  endtask
  task automatic report_and_stop;
    $display("tests %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #20000;
    num_errors++;
    report_and_stop;
  end
  initial begin
    repeat (4) @(negedge clk);
    rstn = 1;
    chk(cnt, 32'hffffffff); chk(ocv, 32'h0); chk({28'h0, m, en, irq}, 32'h0);
    drv(2'h0, 1, 1, 32'h2, 2'h1); drv(2'h2, 0, 0, 32'h2, 2'h1);
    chk({30'h0, en, irq}, 32'h3); chk(cnt, 32'h2);
    chk({30'h0, sst, tst}, 32'h0);
    wirq; chk(n, 32'h3);
    drv(2'h0, 1, 0, 32'h4, 2'h1); wirq; chk(n, 32'h1); chk(cnt, 32'h4);
    drv(2'h2, 0, 0, 32'h4, 2'h1); chk(cnt, 32'h4); chk({31'h0, irq}, 32'h1);
    drv(2'h1, 0, 0, 32'h4, 2'h1); g = 32'h3; chk({30'h0, en, irq}, 32'h0);
    repeat (3) @(negedge clk); chk(cnt, g);
    $display("interval test done");
    drv(2'h0, 1, 1, 32'h5, 2'h2); chk(cnt, 32'h0);
    drv(2'h2, 0, 0, 32'h5, 2'h2); wirq; chk(n, 32'h6);
    drv(2'h2, 0, 1, 32'h5, 2'h3); chk(cnt, 32'h8); chk({30'h0, m}, 32'h2);
    drv(2'h1, 0, 0, 32'h5, 2'h2); drv(2'h2, 0, 0, 32'h5, 2'h2); chk(cnt, 32'h0);
    drv(2'h1, 0, 0, 32'h5, 2'h2);
    $display("free-run test done");
    drv(2'h0, 1, 1, 32'h0, 2'h1); chk(cnt, 32'hffffffff);
    drv(2'h2, 0, 0, 32'h0, 2'h1);
    repeat (4) begin @(negedge clk); chk(irq, 32'h1); end
    drv(2'h1, 0, 0, 32'h0, 2'h1); chk({31'h0, irq}, 32'h0);
    drv(2'h0, 1, 1, 32'h0, 2'h3); drv(2'h2, 0, 0, 32'h0, 2'h3);
    chk({31'h0, irq}, 32'h1);
    @(negedge clk); chk({31'h0, irq}, 32'h1);
    @(negedge clk); chk({31'h0, irq}, 32'h0);
    $display("zero compare test done");
    report_and_stop;
  end
endmodule // ost_timer_bench
`default_nettype wire
